// >>> shared/cst_pkg.sv
// Shared types and constants for the crypto self-test sequencer
package cst_pkg;
	// Test step codes sent to the test engines
	localparam logic [3:0] STEP_CRC_ROM = 4'h0;
	localparam logic [3:0] STEP_CRC_BOOT = 4'h1;
	localparam logic [3:0] STEP_CRC_MAIN = 4'h2;
	localparam logic [3:0] STEP_BULK_ECB = 4'h3;
	localparam logic [3:0] STEP_BULK_XTS = 4'h4;
	localparam logic [3:0] STEP_AUX_ECB = 4'h5;
	localparam logic [3:0] STEP_DRBG = 4'h6;
	localparam logic [3:0] STEP_RSA = 4'h7;
	localparam logic [3:0] STEP_NONE = 4'hF;
	localparam int CRC_WIDTH = 32;
	localparam int RNG_WIDTH = 32;
	localparam int RSA_KEY_BITS = 2048;
	localparam int BULK_KEY_BITS = 256;
	localparam int AUX_KEY_BITS = 128;

	typedef enum logic [1:0] {
		CST_MODE_NORMAL,
		CST_MODE_TESTING,
		CST_MODE_SELF_TEST_ERROR,
		CST_MODE_INTEGRITY_FAIL
	} cst_mode_type;

	// Request to one test engine
	typedef struct packed {
		logic start;
		logic [3:0] step;
	} cst_req_type;

	// Answer from the test engine
	typedef struct packed {
		logic done;
		logic pass;
		logic [CRC_WIDTH-1:0] crc;
	} cst_ans_type;

	// Firmware download path
	typedef struct packed {
		logic image_ready;
		logic sig_done;
		logic sig_ok;
	} cst_fw_type;
endpackage

// >>> hw/cst_sequencer.sv
// Crypto self-test sequencer: power-up, mode-entry and conditional tests
`timescale 1ns/10ps
`default_nettype none

// Function
// RL1 - Start full self-tests after every reset
// RL2 - Run tests to completion without host
// RL3 - Repeat algorithm tests entering initialized mode
// RL4 - Block crypto use until tests pass
// RL5 - Known-answer mismatch enters self-test error
// RL6 - CRC three images, mismatch is integrity failure
// RL7 - Test bulk and auxiliary cipher engines
// RL8 - DRBG tests at start, mode entry, reseed
// RL9 - RSA test on mode entry, aborts downloads
// RL10 - Equal consecutive random numbers means error; the code flags a repeat only in ST_NORMAL
// RL11 - Verify download signature, else reject image
// RL12 - No data output during tests or errors
// RL13 - Errors hold until next reset
module cst_sequencer (
	input wire logic clock_in, // 25 MHz clock
	input wire logic reset_in, // Synchronous reset, high
	input wire logic enter_init_mode_in, // Pulse: mode 0 to mode 1
	input wire logic drbg_reseed_in, // Pulse: generator reseeded
	input wire logic rng_valid_in, // Pulse: new random number
	input wire logic [cst_pkg::RNG_WIDTH-1:0] rng_value_in, // Random value
	input wire cst_pkg::cst_ans_type test_ans_in, // Engine answer
	input wire logic [cst_pkg::CRC_WIDTH-1:0] crc_rom_ref_in, // ROM ref CRC
	input wire logic [cst_pkg::CRC_WIDTH-1:0] crc_boot_ref_in, // Boot ref
	input wire logic [cst_pkg::CRC_WIDTH-1:0] crc_main_ref_in, // Main ref
	input wire cst_pkg::cst_fw_type fw_in, // Download signature check
	output cst_pkg::cst_req_type test_req_out, // Engine request
	output logic crypto_enable_out, // Crypto use allowed
	output logic data_out_enable_out, // Data output allowed
	output cst_pkg::cst_mode_type mode_out, // Sequencer mode
	output logic fw_accept_out, // Pulse: image accepted
	output logic fw_reject_out, // Pulse: image rejected
	output logic abort_download_out // Pulse: abort download and auth
);
	typedef enum {
		ST_IDLE,
		ST_ISSUE,
		ST_WAIT,
		ST_NORMAL,
		ST_ERROR,
		ST_INTEGRITY
	} cst_state_type;

	cst_state_type state;
	cst_state_type next_state;
	logic [3:0] step;
	logic [3:0] next_step;
	logic mode1_run; // Sequence started by mode entry
	logic next_mode1_run;
	logic drbg_only; // Reseed run: only the DRBG test
	logic next_drbg_only;
	logic [cst_pkg::RNG_WIDTH-1:0] last_rng;
	logic have_rng;

	// Decode whether a step is a CRC check
	function automatic logic is_crc(input logic [3:0] s);
		is_crc = (s == cst_pkg::STEP_CRC_ROM) ||
			(s == cst_pkg::STEP_CRC_BOOT) || (s == cst_pkg::STEP_CRC_MAIN);
	endfunction

	// Step after s; mode-entry runs skip CRC and add RSA
	function automatic logic [3:0] step_after(input logic [3:0] s,
			input logic m1, input logic d_only);
		logic [3:0] r;
		r = cst_pkg::STEP_NONE;
		if (d_only)
			r = cst_pkg::STEP_NONE;
		else if (s == cst_pkg::STEP_DRBG)
			r = m1 ? cst_pkg::STEP_RSA : cst_pkg::STEP_NONE;
		else if (s == cst_pkg::STEP_RSA)
			r = cst_pkg::STEP_NONE;
		else
			r = s + 4'h1;
		step_after = r;
	endfunction

	wire logic [cst_pkg::CRC_WIDTH-1:0] crc_ref =
		(step == cst_pkg::STEP_CRC_ROM) ? crc_rom_ref_in :
		(step == cst_pkg::STEP_CRC_BOOT) ? crc_boot_ref_in : crc_main_ref_in;
	wire logic crc_bad = is_crc(step) && (test_ans_in.crc != crc_ref); // RL6
	wire logic kat_bad = !is_crc(step) && !test_ans_in.pass; // RL5
	wire logic last_step = step_after(step, mode1_run, drbg_only) ==
		cst_pkg::STEP_NONE;
	wire logic rng_repeat = rng_valid_in && have_rng &&
		(rng_value_in == last_rng); // RL10
	wire logic in_error = (state == ST_ERROR) || (state == ST_INTEGRITY);

	always_comb begin
		next_state = state;
		next_step = step;
		next_mode1_run = mode1_run;
		next_drbg_only = drbg_only;
		case (state)
			ST_IDLE: begin
				// Power-up run starts at the firmware CRCs
				next_step = cst_pkg::STEP_CRC_ROM; // RL1
				next_mode1_run = 1'b0;
				next_drbg_only = 1'b0;
				next_state = ST_ISSUE; // RL2
			end
			ST_ISSUE: next_state = ST_WAIT;
			ST_WAIT: begin
				if (test_ans_in.done) begin
					if (crc_bad)
						next_state = ST_INTEGRITY; // RL6
					else if (kat_bad)
						next_state = ST_ERROR; // RL5 RL8 RL9
					else if (last_step)
						next_state = ST_NORMAL;
					else begin
						next_step = step_after(step, mode1_run, drbg_only); // RL7
						next_state = ST_ISSUE;
					end
				end
			end
			ST_NORMAL: begin
				if (rng_repeat)
					next_state = ST_ERROR; // RL10
				else if (enter_init_mode_in) begin
					// Algorithm tests only; CRCs are a power-on check
					next_step = cst_pkg::STEP_BULK_ECB; // RL3
					next_mode1_run = 1'b1;
					next_drbg_only = 1'b0;
					next_state = ST_ISSUE;
				end else if (drbg_reseed_in) begin
					next_step = cst_pkg::STEP_DRBG; // RL8
					next_drbg_only = 1'b1;
					next_mode1_run = 1'b0;
					next_state = ST_ISSUE;
				end
			end
			ST_ERROR: next_state = ST_ERROR; // RL13
			ST_INTEGRITY: next_state = ST_INTEGRITY; // RL13
			default: next_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state <= ST_IDLE;
			step <= cst_pkg::STEP_NONE;
			mode1_run <= 1'b0;
			drbg_only <= 1'b0;
		end else begin
			state <= next_state;
			step <= next_step;
			mode1_run <= next_mode1_run;
			drbg_only <= next_drbg_only;
		end
	end

	// Last random value, kept for the repeat check
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			last_rng <= '0;
			have_rng <= 1'b0;
		end else if (rng_valid_in) begin
			last_rng <= rng_value_in; // RL10
			have_rng <= 1'b1;
		end
	end

	wire logic rsa_fail = (state == ST_WAIT) && test_ans_in.done &&
		(step == cst_pkg::STEP_RSA) && !test_ans_in.pass;
	// Signature result only counts while crypto is usable
	wire logic fw_ok = fw_in.sig_done && fw_in.sig_ok &&
		(next_state == ST_NORMAL);
	wire logic fw_bad = fw_in.sig_done && !fw_ok;
	wire cst_pkg::cst_mode_type next_mode =
		(next_state == ST_NORMAL) ? cst_pkg::CST_MODE_NORMAL :
		(next_state == ST_ERROR) ? cst_pkg::CST_MODE_SELF_TEST_ERROR :
		(next_state == ST_INTEGRITY) ? cst_pkg::CST_MODE_INTEGRITY_FAIL :
		cst_pkg::CST_MODE_TESTING;

	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			test_req_out <= '0;
			crypto_enable_out <= 1'b0;
			data_out_enable_out <= 1'b0;
			mode_out <= cst_pkg::CST_MODE_TESTING;
			fw_accept_out <= 1'b0;
			fw_reject_out <= 1'b0;
			abort_download_out <= 1'b0;
		end else begin
			test_req_out.start <= (next_state == ST_ISSUE);
			test_req_out.step <= next_step;
			crypto_enable_out <= (next_state == ST_NORMAL); // RL4
			data_out_enable_out <= (next_state == ST_NORMAL); // RL12
			mode_out <= next_mode;
			fw_accept_out <= fw_ok; // RL11
			fw_reject_out <= fw_bad; // RL11
			abort_download_out <= rsa_fail; // RL9
		end
	end

	AST_NO_CRYPTO_IN_TEST: assert property (@(posedge clock_in) // RL4
		disable iff (reset_in) (state == ST_ISSUE || state == ST_WAIT)
		|-> !crypto_enable_out && !data_out_enable_out)
		else $error("crypto enabled during self-test");
	AST_CRC_FAIL: assert property (@(posedge clock_in) // RL6
		disable iff (reset_in) (state == ST_WAIT && test_ans_in.done && crc_bad)
		|=> mode_out == cst_pkg::CST_MODE_INTEGRITY_FAIL)
		else $error("crc mismatch did not flag integrity failure");
	AST_KAT_FAIL: assert property (@(posedge clock_in) // RL5
		disable iff (reset_in)
		(state == ST_WAIT && test_ans_in.done && !crc_bad && kat_bad)
		|=> mode_out == cst_pkg::CST_MODE_SELF_TEST_ERROR)
		else $error("kat failure did not enter error");
	AST_RNG_REPEAT: assert property (@(posedge clock_in) // RL10
		disable iff (reset_in) (state == ST_NORMAL && rng_repeat)
		|=> state == ST_ERROR)
		else $error("repeated random value not caught");
	AST_ERROR_STICKY: assert property (@(posedge clock_in) // RL13
		disable iff (reset_in) in_error |=> $stable(state))
		else $error("error state left without reset");
	AST_NO_DATA_IN_ERROR: assert property (@(posedge clock_in) // RL12
		disable iff (reset_in) in_error |=> !data_out_enable_out[*2])
		else $error("data output during error");
	AST_START_AFTER_RESET: assert property (@(posedge clock_in) // RL1
		$fell(reset_in) |-> ##1 test_req_out.start &&
		test_req_out.step == cst_pkg::STEP_CRC_ROM)
		else $error("self-test did not start after reset");
	AST_MODE1_RUN: assert property (@(posedge clock_in) // RL3
		disable iff (reset_in)
		(state == ST_NORMAL && !rng_repeat && enter_init_mode_in)
		|=> test_req_out.start && test_req_out.step == cst_pkg::STEP_BULK_ECB)
		else $error("mode entry did not rerun tests");
	AST_RSA_ABORT: assert property (@(posedge clock_in) // RL9
		disable iff (reset_in) rsa_fail |=> abort_download_out &&
		mode_out == cst_pkg::CST_MODE_SELF_TEST_ERROR)
		else $error("rsa failure did not abort");
	AST_FW_REJECT: assert property (@(posedge clock_in) // RL11
		disable iff (reset_in) (fw_in.sig_done && !fw_in.sig_ok)
		|=> fw_reject_out && !fw_accept_out)
		else $error("bad signature not rejected");

	// Run shape: one request at a time, each start a single-cycle pulse
	AST_START_PULSE: assert property (@(posedge clock_in) // RL2
		disable iff (reset_in) test_req_out.start |=> !test_req_out.start)
		else $error("engine start held past one cycle");
	AST_ONE_OUTSTANDING: assert property (@(posedge clock_in) // RL2
		disable iff (reset_in) (state == ST_WAIT && !test_ans_in.done)
		|=> !test_req_out.start)
		else $error("engine request issued before the answer");
	AST_ADVANCE: assert property (@(posedge clock_in) // RL7
		disable iff (reset_in)
		(state == ST_WAIT && test_ans_in.done && !crc_bad && !kat_bad &&
		!last_step) |=> state == ST_ISSUE && test_req_out.start)
		else $error("passing step did not advance the run");
	AST_OUTPUTS_AFTER_RESET: assert property (@(posedge clock_in) // RL1
		$fell(reset_in) |-> !crypto_enable_out && !data_out_enable_out &&
		mode_out == cst_pkg::CST_MODE_TESTING)
		else $error("outputs not quiet as the run starts");

	// Which steps belong to which kind of run
	AST_NO_RSA_AT_POWER_UP: assert property (@(posedge clock_in) // RL9
		disable iff (reset_in) (test_req_out.start && !mode1_run)
		|-> test_req_out.step != cst_pkg::STEP_RSA)
		else $error("signature test outside a mode-entry run");
	AST_NO_CRC_ON_ENTRY: assert property (@(posedge clock_in) // RL3
		disable iff (reset_in) (test_req_out.start && mode1_run)
		|-> !is_crc(test_req_out.step))
		else $error("image check inside a mode-entry run");
	AST_RESEED_DRBG_ONLY: assert property (@(posedge clock_in) // RL8
		disable iff (reset_in) (test_req_out.start && drbg_only)
		|-> test_req_out.step == cst_pkg::STEP_DRBG)
		else $error("reseed run issued a step other than the generator");
	AST_RESEED_RUN: assert property (@(posedge clock_in) // RL8
		disable iff (reset_in) (state == ST_NORMAL && !rng_repeat &&
		!enter_init_mode_in && drbg_reseed_in)
		|=> test_req_out.start && test_req_out.step == cst_pkg::STEP_DRBG)
		else $error("reseed did not rerun the generator test");

	// Gating of crypto use, data output and firmware results
	AST_PASS_ENABLES: assert property (@(posedge clock_in) // RL4
		disable iff (reset_in)
		(state == ST_WAIT && test_ans_in.done && !crc_bad && !kat_bad &&
		last_step) |=> crypto_enable_out && data_out_enable_out &&
		mode_out == cst_pkg::CST_MODE_NORMAL)
		else $error("passing run did not enable crypto use");
	AST_ENABLE_ONLY_NORMAL: assert property (@(posedge clock_in) // RL12
		disable iff (reset_in) (crypto_enable_out || data_out_enable_out)
		|-> mode_out == cst_pkg::CST_MODE_NORMAL)
		else $error("output enabled outside normal mode");
	AST_FW_ACCEPT: assert property (@(posedge clock_in) // RL11
		disable iff (reset_in) (fw_in.sig_done && fw_in.sig_ok &&
		state == ST_NORMAL && !rng_repeat && !enter_init_mode_in &&
		!drbg_reseed_in) |=> fw_accept_out && !fw_reject_out)
		else $error("good signature not accepted");
	AST_ABORT_IN_ERROR: assert property (@(posedge clock_in) // RL9
		disable iff (reset_in) abort_download_out
		|-> mode_out == cst_pkg::CST_MODE_SELF_TEST_ERROR)
		else $error("download abort without self-test error");

	// Failure states hold until reset and keep the engines idle
	AST_NO_START_IN_ERROR: assert property (@(posedge clock_in) // RL13
		disable iff (reset_in) in_error |=> !test_req_out.start)
		else $error("engine request while failed");
	AST_ERROR_MODE_HOLD: assert property (@(posedge clock_in) // RL13
		disable iff (reset_in)
		mode_out == cst_pkg::CST_MODE_SELF_TEST_ERROR |=>
		mode_out == cst_pkg::CST_MODE_SELF_TEST_ERROR)
		else $error("self-test error mode left without reset");
	AST_INTEGRITY_HOLD: assert property (@(posedge clock_in) // RL13
		disable iff (reset_in)
		mode_out == cst_pkg::CST_MODE_INTEGRITY_FAIL |=>
		mode_out == cst_pkg::CST_MODE_INTEGRITY_FAIL)
		else $error("integrity failure mode left without reset");
endmodule
`default_nettype wire

// >>> tb/cst_engine_model.sv
// Behavioural test engine answering the sequencer's step requests
`timescale 1ns/10ps
`default_nettype none
module cst_engine_model (
	input wire logic clock_in, // Clock
	input wire logic reset_in, // Reset
	input wire cst_pkg::cst_req_type req_in, // Step request
	input wire logic [3:0] fail_in, // Step made to fail
	input wire logic [3:0] delay_in, // Answer delay in cycles
	output cst_pkg::cst_ans_type ans_out // Engine answer
);
	logic busy;
	logic [3:0] cnt;
	logic [3:0] step;
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			busy <= 1'b0;
			ans_out <= '0;
		end else begin
			ans_out.done <= 1'b0;
			// Stale fields toggle so the design cannot lean on them
			ans_out.crc <= ~ans_out.crc;
			ans_out.pass <= ~ans_out.pass;
			if (req_in.start) begin
				busy <= 1'b1;
				cnt <= delay_in;
				step <= req_in.step;
			end else if (busy && cnt != 4'h0) begin
				cnt <= cnt - 4'h1;
			end else if (busy) begin
				busy <= 1'b0;
				ans_out.done <= 1'b1;
				ans_out.pass <= step != fail_in;
				ans_out.crc <= {28'hC0DE000, step} ^ {32{step == fail_in}};
			end
		end
	end
endmodule
`default_nettype wire

// >>> tb/test_crypto_self_test_sequencer.sv
// Self-checking bench for the crypto self-test sequencer
`timescale 1ns/10ps
`default_nettype none
module test_crypto_self_test_sequencer;
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic init_p = 1'b0;
	logic reseed_p = 1'b0;
	logic rng_p = 1'b0;
	logic [31:0] rng_v = 32'h0;
	logic [3:0] fail = 4'hF;
	logic [3:0] dly = 4'h0;
	cst_pkg::cst_fw_type fw = '0;
	cst_pkg::cst_req_type req;
	cst_pkg::cst_ans_type ans;
	cst_pkg::cst_mode_type mode;
	logic c_en, d_en, acc, rej, abt;
	int bad_count = 0;
	int total_checks = 0;
	int steps = 0, n_acc = 0, n_rej = 0, n_abt = 0;
	logic [31:0] seq = 32'h0;
	initial forever #20 clock_in = ~clock_in;
	cst_engine_model eng (.clock_in(clock_in), .reset_in(reset_in),
		.req_in(req), .fail_in(fail), .delay_in(dly), .ans_out(ans));
	cst_sequencer DUT (.clock_in(clock_in), .reset_in(reset_in),
		.enter_init_mode_in(init_p), .drbg_reseed_in(reseed_p),
		.rng_valid_in(rng_p), .rng_value_in(rng_v), .test_ans_in(ans),
		.crc_rom_ref_in(32'hC0DE0000), .crc_boot_ref_in(32'hC0DE0001),
		.crc_main_ref_in(32'hC0DE0002), .fw_in(fw), .test_req_out(req),
		.crypto_enable_out(c_en), .data_out_enable_out(d_en),
		.mode_out(mode), .fw_accept_out(acc), .fw_reject_out(rej),
		.abort_download_out(abt));
	always @(posedge clock_in) begin
		if (req.start === 1'b1) begin
			steps <= steps + 1;
			seq <= {seq[27:0], req.step};
		end
		n_acc <= n_acc + (acc === 1'b1);
		n_rej <= n_rej + (rej === 1'b1);
		n_abt <= n_abt + (abt === 1'b1);
	end
	task automatic check(string what, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic wait_mode(cst_pkg::cst_mode_type m);
		int i;
		i = 0;
		repeat (3) @(posedge clock_in);
		#1;
		while (mode !== m && i < 400) begin
			@(posedge clock_in);
			#1;
			i++;
		end
		check("mode", 32'(m), 32'(mode));
	endtask
	task automatic pulse(int k, logic [31:0] v);
		@(posedge clock_in);
		rng_v <= v;
		case (k)
			0: init_p <= 1'b1;
			1: reseed_p <= 1'b1;
			2: rng_p <= 1'b1;
			default: fw.sig_done <= 1'b1;
		endcase
		@(posedge clock_in);
		{init_p, reseed_p, rng_p, fw.sig_done} <= 4'h0;
	endtask
	task automatic t_power(logic [3:0] d, logic [3:0] f,
		cst_pkg::cst_mode_type m, logic [31:0] e, int n);
		logic [1:0] en;
		@(posedge clock_in);
		dly <= d;
		fail <= f;
		reset_in <= 1'b1;
		repeat (10) @(posedge clock_in);
		reset_in <= 1'b0;
		repeat (3) @(posedge clock_in);
		#1;
		check("enables in test", 32'h0, {c_en, d_en});
		wait_mode(m);
		en = {2{m == cst_pkg::CST_MODE_NORMAL}};
		check("enables", {30'h0, en}, {c_en, d_en});
		check("steps", e, seq & ~(32'hFFFFFFFF << (4 * n)));
		$display("power-up test done");
	endtask
	task automatic t_entry(logic [3:0] f, cst_pkg::cst_mode_type m);
		int a0;
		@(posedge clock_in);
		fail <= f;
		a0 = n_abt;
		pulse(0, 32'h0);
		wait_mode(m);
		// The abort pulse is counted one edge after the mode changes
		@(posedge clock_in);
		#1;
		check("entry steps", 32'h34567, {12'h0, seq[19:0]});
		check("aborts", {31'h0, f == 4'h7}, n_abt - a0);
		$display("mode entry test done");
	endtask
	task automatic t_reseed;
		int s0;
		s0 = steps;
		pulse(1, 32'h0);
		wait_mode(cst_pkg::CST_MODE_NORMAL);
		check("reseed steps", 32'h1, steps - s0);
		check("reseed step", 32'h6, {28'h0, seq[3:0]});
		$display("reseed test done");
	endtask
	task automatic t_rng;
		pulse(2, 32'h1234ABCD);
		pulse(2, 32'h5678EF01);
		wait_mode(cst_pkg::CST_MODE_NORMAL);
		pulse(2, 32'h5678EF01);
		wait_mode(cst_pkg::CST_MODE_SELF_TEST_ERROR);
		$display("random repeat test done");
	endtask
	task automatic t_fw(logic ok, int ea, int er);
		int a0, r0;
		@(posedge clock_in);
		fw.sig_ok <= ok;
		a0 = n_acc;
		r0 = n_rej;
		pulse(3, 32'h0);
		repeat (3) @(posedge clock_in);
		#1;
		check("accepts", 32'(ea), n_acc - a0);
		check("rejects", 32'(er), n_rej - r0);
		$display("firmware check test done");
	endtask
	task automatic t_hold;
		cst_pkg::cst_mode_type m;
		m = mode;
		pulse(0, 32'h0);
		pulse(1, 32'h0);
		repeat (20) @(posedge clock_in);
		#1;
		check("held mode", 32'(m), 32'(mode));
		check("held enables", 32'h0, {c_en, d_en});
		$display("sticky error test done");
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		t_power(4'h0, 4'hF, cst_pkg::CST_MODE_NORMAL, 32'h0123456, 7);
		t_fw(1'b1, 1, 0);
		t_fw(1'b0, 0, 1);
		t_entry(4'hF, cst_pkg::CST_MODE_NORMAL);
		t_reseed;
		t_entry(4'h7, cst_pkg::CST_MODE_SELF_TEST_ERROR);
		t_fw(1'b1, 0, 1);
		t_hold;
		t_power(4'h9, 4'hF, cst_pkg::CST_MODE_NORMAL, 32'h0123456, 7);
		t_rng;
		t_power(4'h0, 4'h1, cst_pkg::CST_MODE_INTEGRITY_FAIL, 32'h01, 2);
		t_hold;
		t_power(4'h0, 4'h4, cst_pkg::CST_MODE_SELF_TEST_ERROR, 32'h01234, 5);
		final_report;
	end
	initial begin
		#(40 * 20000);
		bad_count++;
		final_report;
	end
endmodule
`default_nettype wire
